// ---- rtl/move_arith_pkg.sv ----
// shared opcodes, addresses and timing for the move/arithmetic executor
package move_arith_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int ROM_ADDR_W = 16;
  localparam int OP_W = 5;
  // opcodes presented on op with start
  localparam logic [4:0] OP_MOV_AM = 5'h00;
  localparam logic [4:0] OP_MOV_MA = 5'h01;
  localparam logic [4:0] OP_BANK0_MOVE_AM = 5'h02;
  localparam logic [4:0] OP_BANK0_MOVE_MA = 5'h03;
  localparam logic [4:0] OP_MOV_AI = 5'h04;
  localparam logic [4:0] OP_BANK0_MOVE_MI = 5'h05;
  localparam logic [4:0] OP_SWAP_ACC_MEM = 5'h06;
  localparam logic [4:0] OP_BANK0_EXCHANGE = 5'h07;
  localparam logic [4:0] OP_ROM_TABLE_READ = 5'h08;
  localparam logic [4:0] OP_ADC_AM = 5'h09;
  localparam logic [4:0] OP_ADC_MA = 5'h0a;
  localparam logic [4:0] OP_ADD_AM = 5'h0b;
  localparam logic [4:0] OP_ADD_MA = 5'h0c;
  localparam logic [4:0] OP_BANK0_ADD = 5'h0d;
  localparam logic [4:0] OP_ADD_AI = 5'h0e;
  localparam logic [4:0] OP_SBC_AM = 5'h0f;
  localparam logic [4:0] OP_SBC_MA = 5'h10;
  localparam logic [4:0] OP_SUB_AM = 5'h11;
  localparam logic [4:0] OP_SUB_MA = 5'h12;
  localparam logic [4:0] OP_SUB_AI = 5'h13;
  localparam logic [4:0] OP_MULTIPLY_8X8 = 5'h14;
  // memory map: system registers from 0x80 up, general ram below
  localparam logic [7:0] SYS_BASE = 8'h80;
  localparam logic [7:0] IMM_LO = 8'h80;
  localparam logic [7:0] IMM_HI = 8'h87;
  localparam logic [7:0] ADDR_PROD_HIGH = 8'h82;
  localparam logic [7:0] ADDR_PTR_LOW = 8'h83;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h84;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [3:0] NIB_MASK = 4'hf;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ROM = 3'b100
  } exec_state_t;
endpackage

// ---- rtl/move_arith_instr_exec.sv ----
// move and arithmetic instruction executor with its own data memory
// Functional notes
// RULE_01 - bank0 load to acc, one cycle, zero updated
// RULE_02 - bank0 store from acc, one cycle, flags kept
// RULE_03 - immediate store only to 0x80..0x87
// RULE_04 - exchange swaps acc and memory, 1+N cycles
// RULE_05 - table read: rom word to prod-high and acc
// RULE_06 - add-with-carry sets carry, digit carry, zero
// RULE_07 - plain add sets carry, digit carry, zero
// RULE_08 - bank0 add writes memory, 1+N cycles
// RULE_09 - subtract-with-borrow: carry clear on borrow
// RULE_10 - subtract: carry clear on borrow, else set
// RULE_11 - multiply: low to acc, high to prod-high
// RULE_12 - N is 0 for system, 1 for ram
// RULE_13 - memory forms keep accumulator-form flag rules
`timescale 1ns/1ns
module move_arith_instr_exec #(
  parameter int MEM_DEPTH = 256
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [4:0] op,
  input wire logic [7:0] addr,
  input wire logic [7:0] imm,
  input wire logic load_en,
  input wire logic [7:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [7:0] peek_addr,
  input wire logic [7:0] rom_data_lo,
  input wire logic [7:0] rom_data_hi,
  output logic [15:0] rom_addr,
  output logic rom_rd,
  output logic [7:0] acc,
  output logic carry,
  output logic digit_carry_flag,
  output logic zero,
  output logic busy,
  output logic done,
  output logic bad_target,
  output logic [7:0] peek_data
);
  logic [7:0] mem [0:MEM_DEPTH-1];
  move_arith_pkg::exec_state_t state_reg;
  logic [1:0] wait_reg;
  logic take;
  logic [7:0] mem_rd;
  logic [7:0] acc_next;
  logic acc_we;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic [7:0] prod_high_next;
  logic prod_high_we;
  logic flag_cz_we;
  logic zero_we;
  logic [9:0] alu;
  logic [1:0] cycles;
  logic imm_bad;
  logic [15:0] product;

  // 8-bit add returning {carry, digit carry, sum}; subtract feeds ~b
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
    input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add8 = {full[8], lo[4], full[7:0]};
  endfunction

  // memory ops cost one extra cycle only when aimed at general ram
  function automatic logic [1:0] cost(input logic [7:0] a);
    cost = (a < move_arith_pkg::SYS_BASE) ? move_arith_pkg::CYC_TWO : move_arith_pkg::CYC_ONE;
  endfunction

  assign take = start && (state_reg == move_arith_pkg::ST_IDLE);
  assign mem_rd = mem[addr];
  assign imm_bad = (addr < move_arith_pkg::IMM_LO) || (addr > move_arith_pkg::IMM_HI);
  assign product = acc * mem_rd;

  // decode and compute the instruction taken this cycle
  always_comb
  begin
    acc_next = acc;
    acc_we = 1'b0;
    mem_wdata = acc;
    mem_we = 1'b0;
    prod_high_next = product[15:8];
    prod_high_we = 1'b0;
    flag_cz_we = 1'b0;
    zero_we = 1'b0;
    alu = {2'b00, acc};
    cycles = move_arith_pkg::CYC_ONE;
    case (op)
      move_arith_pkg::OP_MOV_AM, move_arith_pkg::OP_BANK0_MOVE_AM:
      begin
        acc_next = mem_rd; // RULE_01
        acc_we = 1'b1;
        zero_we = 1'b1;
      end
      move_arith_pkg::OP_MOV_MA, move_arith_pkg::OP_BANK0_MOVE_MA:
        mem_we = 1'b1; // RULE_02
      move_arith_pkg::OP_MOV_AI:
      begin
        acc_next = imm;
        acc_we = 1'b1;
      end
      move_arith_pkg::OP_BANK0_MOVE_MI:
      begin
        mem_wdata = imm;
        mem_we = !imm_bad; // RULE_03
      end
      move_arith_pkg::OP_SWAP_ACC_MEM, move_arith_pkg::OP_BANK0_EXCHANGE:
      begin
        acc_next = mem_rd; // RULE_04
        acc_we = 1'b1;
        mem_we = 1'b1;
        cycles = cost(addr); // RULE_12
      end
      move_arith_pkg::OP_ROM_TABLE_READ:
        cycles = move_arith_pkg::CYC_TWO; // RULE_05
      move_arith_pkg::OP_ADC_AM, move_arith_pkg::OP_ADC_MA:
        alu = add8(acc, mem_rd, carry); // RULE_06
      move_arith_pkg::OP_ADD_AM, move_arith_pkg::OP_ADD_MA, move_arith_pkg::OP_BANK0_ADD:
        alu = add8(acc, mem_rd, 1'b0); // RULE_07 RULE_08
      move_arith_pkg::OP_ADD_AI:
        alu = add8(acc, imm, 1'b0); // RULE_07
      move_arith_pkg::OP_SBC_AM, move_arith_pkg::OP_SBC_MA:
        alu = add8(acc, ~mem_rd, carry); // RULE_09
      move_arith_pkg::OP_SUB_AM, move_arith_pkg::OP_SUB_MA:
        alu = add8(acc, ~mem_rd, 1'b1); // RULE_10
      move_arith_pkg::OP_SUB_AI:
        alu = add8(acc, ~imm, 1'b1); // RULE_10
      move_arith_pkg::OP_MULTIPLY_8X8:
      begin
        acc_next = product[7:0]; // RULE_11
        acc_we = 1'b1;
        prod_high_we = 1'b1;
        zero_we = 1'b1;
        cycles = move_arith_pkg::CYC_TWO;
      end
      default:
        cycles = move_arith_pkg::CYC_ONE;
    endcase
    // arithmetic: accumulator forms one cycle, memory forms 1+N
    case (op)
      move_arith_pkg::OP_ADC_AM, move_arith_pkg::OP_ADD_AM, move_arith_pkg::OP_ADD_AI,
      move_arith_pkg::OP_SBC_AM, move_arith_pkg::OP_SUB_AM, move_arith_pkg::OP_SUB_AI:
      begin
        acc_next = alu[7:0];
        acc_we = 1'b1;
        flag_cz_we = 1'b1;
        zero_we = 1'b1;
      end
      move_arith_pkg::OP_ADC_MA, move_arith_pkg::OP_ADD_MA, move_arith_pkg::OP_BANK0_ADD,
      move_arith_pkg::OP_SBC_MA, move_arith_pkg::OP_SUB_MA:
      begin
        mem_wdata = alu[7:0];
        mem_we = 1'b1;
        flag_cz_we = 1'b1; // RULE_13
        zero_we = 1'b1;
        cycles = cost(addr); // RULE_08 RULE_12
      end
      default:
        flag_cz_we = 1'b0;
    endcase
  end

  // sequencing: extra cycles stretch busy; table read waits one rom cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= move_arith_pkg::ST_IDLE;
      wait_reg <= 2'h0;
      done <= 1'b0;
      rom_rd <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      rom_rd <= 1'b0;
      case (state_reg)
        move_arith_pkg::ST_IDLE:
          if (take)
          begin
            if (op == move_arith_pkg::OP_ROM_TABLE_READ)
            begin
              state_reg <= move_arith_pkg::ST_ROM; // RULE_05
              rom_rd <= 1'b1;
              busy <= 1'b1;
            end
            else if (cycles == move_arith_pkg::CYC_ONE)
              done <= 1'b1;
            else
            begin
              state_reg <= move_arith_pkg::ST_WAIT;
              wait_reg <= cycles - move_arith_pkg::CYC_ONE;
              busy <= 1'b1; // RULE_12
            end
          end
        move_arith_pkg::ST_WAIT:
        begin
          wait_reg <= wait_reg - move_arith_pkg::CYC_ONE;
          if (wait_reg == move_arith_pkg::CYC_ONE)
          begin
            state_reg <= move_arith_pkg::ST_IDLE;
            done <= 1'b1;
            busy <= 1'b0;
          end
        end
        move_arith_pkg::ST_ROM:
        begin
          state_reg <= move_arith_pkg::ST_IDLE;
          done <= 1'b1;
          busy <= 1'b0;
        end
        default:
        begin
          state_reg <= move_arith_pkg::ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // rom pointer taken from the pointer register pair at issue
  always_ff @(posedge clk)
  begin
    if (srst)
      rom_addr <= 16'h0000;
    else if (take && op == move_arith_pkg::OP_ROM_TABLE_READ)
      rom_addr <= {mem[move_arith_pkg::ADDR_PTR_HIGH], mem[move_arith_pkg::ADDR_PTR_LOW]}; // RULE_05
  end

  // accumulator; table read lands one cycle after the address goes out
  always_ff @(posedge clk)
  begin
    if (srst)
      acc <= move_arith_pkg::RESET_BYTE;
    else if (state_reg == move_arith_pkg::ST_ROM)
      acc <= rom_data_lo; // RULE_05
    else if (take && acc_we)
      acc <= acc_next;
  end

  // flags; zero follows memory loads, arithmetic and multiply; other ops keep it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      carry <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero <= 1'b0;
    end
    else if (take)
    begin
      if (flag_cz_we)
      begin
        carry <= alu[9]; // RULE_06 RULE_07 RULE_09 RULE_10
        digit_carry_flag <= alu[8];
      end
      if (zero_we)
        zero <= flag_cz_we ? (alu[7:0] == 8'h00) : (acc_next == 8'h00); // RULE_01 RULE_11
    end
  end

  // flagged when an immediate store aims outside the supported window
  always_ff @(posedge clk)
  begin
    if (srst)
      bad_target <= 1'b0;
    else
      bad_target <= take && op == move_arith_pkg::OP_BANK0_MOVE_MI && imm_bad; // RULE_03
  end

  // data memory; no reset, loader only while idle to avoid write races
  always_ff @(posedge clk)
  begin
    if (state_reg == move_arith_pkg::ST_ROM)
      mem[move_arith_pkg::ADDR_PROD_HIGH] <= rom_data_hi; // RULE_05
    else if (take && prod_high_we)
      mem[move_arith_pkg::ADDR_PROD_HIGH] <= prod_high_next; // RULE_11
    if (take && mem_we)
      mem[addr] <= mem_wdata;
    else if (load_en && !busy && !start)
      mem[load_addr] <= load_data;
  end

  // registered observation port
  always_ff @(posedge clk)
  begin
    if (srst)
      peek_data <= move_arith_pkg::RESET_BYTE;
    else
      peek_data <= mem[peek_addr];
  end

  // checks
  property p_load_zero;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_BANK0_MOVE_AM |=> acc == $past(mem_rd)
      && zero == ($past(mem_rd) == 8'h00) && done;
  endproperty
  a_load_zero: assert property (p_load_zero) else $error("bank0 load wrong"); // RULE_01
  property p_store_flags;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_BANK0_MOVE_MA |=> $stable(carry) && $stable(zero)
      && $stable(digit_carry_flag) && done;
  endproperty
  a_store_flags: assert property (p_store_flags) else $error("store changed flags"); // RULE_02
  property p_imm_bad;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_BANK0_MOVE_MI |=> bad_target == $past(imm_bad);
  endproperty
  a_imm_bad: assert property (p_imm_bad) else $error("immediate target check wrong"); // RULE_03
  property p_xch_ram;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_SWAP_ACC_MEM && addr < move_arith_pkg::SYS_BASE
      |=> busy && !done ##1 done && !busy;
  endproperty
  a_xch_ram: assert property (p_xch_ram) else $error("exchange timing wrong"); // RULE_04 RULE_12
  property p_rom;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_ROM_TABLE_READ |=> rom_rd ##1 done && acc == $past(rom_data_lo);
  endproperty
  a_rom: assert property (p_rom) else $error("table read wrong"); // RULE_05
  property p_adc;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_ADC_AM
      |=> {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(mem_rd)} + {8'h00, $past(carry)};
  endproperty
  a_adc: assert property (p_adc) else $error("add with carry wrong"); // RULE_06
  property p_add_imm;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_ADD_AI
      |=> {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(imm)} && zero == (acc == 8'h00);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate wrong"); // RULE_07
  property p_bank0_add_flags;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_BANK0_ADD
      |=> carry == ({1'b0, $past(acc)} + {1'b0, $past(mem_rd)} > 9'h0ff) && $stable(acc);
  endproperty
  a_bank0_add_flags: assert property (p_bank0_add_flags) else $error("bank0 add wrong"); // RULE_08 RULE_13
  property p_sub;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_SUB_AM
      |=> carry == ($past(acc) >= $past(mem_rd)) && acc == 8'($past(acc) - $past(mem_rd));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract wrong"); // RULE_10
  property p_sbc;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_SBC_AM && !carry
      |=> carry == ($past(acc) > $past(mem_rd));
  endproperty
  a_sbc: assert property (p_sbc) else $error("subtract with borrow wrong"); // RULE_09
  property p_mul;
    @(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_MULTIPLY_8X8
      |=> acc == $past(product[7:0]) && zero == (acc == 8'h00) && busy ##1 done;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong"); // RULE_11
  c_rom: cover property (@(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_ROM_TABLE_READ);
  c_adc_carry: cover property (@(posedge clk) disable iff (srst)
    take && op == move_arith_pkg::OP_ADC_AM && alu[9]);
  c_bad_imm: cover property (@(posedge clk) disable iff (srst) bad_target);
endmodule

// ---- verification/move_arith_instr_exec_tb.sv ----
// self-checking bench for the move and arithmetic executor
`timescale 1ns/1ns
module move_arith_instr_exec_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic [4:0] op = 5'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] imm = 8'h00;
  logic load_en = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic [7:0] peek_addr = 8'h00;
  logic [7:0] rom_data_lo = 8'h00;
  logic [7:0] rom_data_hi = 8'h00;
  logic [15:0] rom_addr;
  logic rom_rd;
  logic carry;
  logic digit_carry_flag;
  logic zero;
  logic busy;
  logic done;
  logic bad_target;
  logic [7:0] acc;
  logic [7:0] peek_data;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] lfsr_reg = 16'h0034;
  // reference state kept by the bench
  logic [7:0] mem_m [256];
  logic [7:0] acc_m = 8'h00;
  logic c_m = 1'b0;
  logic dc_m = 1'b0;
  logic z_m = 1'b0;
  // hand-picked corners: op, address, immediate
  logic [20:0] corner [16] = '{
    {move_arith_pkg::OP_MOV_AI, 8'h00, 8'hff},
    {move_arith_pkg::OP_ADD_AI, 8'h00, 8'h01},
    {move_arith_pkg::OP_ADC_AM, 8'h10, 8'h00},
    {move_arith_pkg::OP_SUB_AI, 8'h00, 8'h01},
    {move_arith_pkg::OP_SBC_AM, 8'h20, 8'h00},
    {move_arith_pkg::OP_BANK0_MOVE_MI, 8'h87, 8'h5a},
    {move_arith_pkg::OP_BANK0_MOVE_MI, 8'h88, 8'ha5},
    {move_arith_pkg::OP_BANK0_MOVE_MI, 8'h7f, 8'h3c},
    {move_arith_pkg::OP_MOV_AI, 8'h00, 8'h00},
    {move_arith_pkg::OP_MULTIPLY_8X8, 8'h10, 8'h00},
    {move_arith_pkg::OP_BANK0_ADD, 8'h90, 8'h00},
    {move_arith_pkg::OP_BANK0_ADD, 8'h10, 8'h00},
    {move_arith_pkg::OP_BANK0_EXCHANGE, 8'h85, 8'h00},
    {move_arith_pkg::OP_SWAP_ACC_MEM, 8'h05, 8'h00},
    {move_arith_pkg::OP_ROM_TABLE_READ, 8'h00, 8'h00},
    {move_arith_pkg::OP_SUB_MA, 8'h30, 8'h00}
  };

  move_arith_instr_exec #(.MEM_DEPTH(256)) move_arith_instr_exec_i (
    .clk(clk), .srst(srst), .start(start), .op(op), .addr(addr), .imm(imm),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .peek_addr(peek_addr), .rom_data_lo(rom_data_lo), .rom_data_hi(rom_data_hi),
    .rom_addr(rom_addr), .rom_rd(rom_rd), .acc(acc), .carry(carry),
    .digit_carry_flag(digit_carry_flag), .zero(zero), .busy(busy), .done(done),
    .bad_target(bad_target), .peek_data(peek_data)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count = fail_count + 1;
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // eight shifts per byte so successive bytes are not mere shifts of each other
  task automatic rnd(output logic [7:0] v);
    repeat (8) lfsr_reg = lfsr_next(lfsr_reg);
    v = lfsr_reg[7:0];
  endtask

  // one adder serves add and subtract: subtract feeds the inverted operand
  function automatic logic [7:0] alu(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    s = a + b + cin;
    c_m = s[8];
    dc_m = (a[3:0] + b[3:0] + cin) > 5'h0f;
    z_m = (s[7:0] == 8'h00);
    return s[7:0];
  endfunction

  // updates the reference state, returns expected done latency (0: refused)
  function automatic int model(input logic [4:0] o, input logic [7:0] a, input logic [7:0] i);
    logic [7:0] m;
    logic [15:0] p;
    int n;
    m = mem_m[a];
    n = (a < move_arith_pkg::SYS_BASE) ? 2 : 1;
    case (o)
      move_arith_pkg::OP_MOV_AM, move_arith_pkg::OP_BANK0_MOVE_AM:
      begin
        acc_m = m;
        z_m = (m == 8'h00);
      end
      move_arith_pkg::OP_MOV_MA, move_arith_pkg::OP_BANK0_MOVE_MA: mem_m[a] = acc_m;
      move_arith_pkg::OP_MOV_AI: acc_m = i;
      move_arith_pkg::OP_BANK0_MOVE_MI:
      begin
        if (a < move_arith_pkg::IMM_LO || a > move_arith_pkg::IMM_HI)
          return 0;
        mem_m[a] = i;
      end
      move_arith_pkg::OP_SWAP_ACC_MEM, move_arith_pkg::OP_BANK0_EXCHANGE:
      begin
        mem_m[a] = acc_m;
        acc_m = m;
      end
      move_arith_pkg::OP_ROM_TABLE_READ:
      begin
        acc_m = rom_data_lo;
        mem_m[move_arith_pkg::ADDR_PROD_HIGH] = rom_data_hi;
        return 2;
      end
      move_arith_pkg::OP_MULTIPLY_8X8:
      begin
        p = acc_m * m;
        acc_m = p[7:0];
        mem_m[move_arith_pkg::ADDR_PROD_HIGH] = p[15:8];
        z_m = (p[7:0] == 8'h00);
        return 2;
      end
      move_arith_pkg::OP_ADC_AM: acc_m = alu(acc_m, m, c_m);
      move_arith_pkg::OP_ADC_MA: mem_m[a] = alu(acc_m, m, c_m);
      move_arith_pkg::OP_ADD_AM: acc_m = alu(acc_m, m, 1'b0);
      move_arith_pkg::OP_ADD_MA, move_arith_pkg::OP_BANK0_ADD: mem_m[a] = alu(acc_m, m, 1'b0);
      move_arith_pkg::OP_ADD_AI: acc_m = alu(acc_m, i, 1'b0);
      move_arith_pkg::OP_SBC_AM: acc_m = alu(acc_m, ~m, c_m);
      move_arith_pkg::OP_SBC_MA: mem_m[a] = alu(acc_m, ~m, c_m);
      move_arith_pkg::OP_SUB_AM: acc_m = alu(acc_m, ~m, 1'b1);
      move_arith_pkg::OP_SUB_MA: mem_m[a] = alu(acc_m, ~m, 1'b1);
      move_arith_pkg::OP_SUB_AI: acc_m = alu(acc_m, ~i, 1'b1);
      default: ;
    endcase
    return (o inside {move_arith_pkg::OP_ADC_MA, move_arith_pkg::OP_ADD_MA,
      move_arith_pkg::OP_BANK0_ADD, move_arith_pkg::OP_SBC_MA, move_arith_pkg::OP_SUB_MA,
      move_arith_pkg::OP_SWAP_ACC_MEM, move_arith_pkg::OP_BANK0_EXCHANGE}) ? n : 1;
  endfunction

  // memory is seen only through the registered peek port
  task automatic peek(input logic [7:0] a);
    @(posedge clk);
    peek_addr <= a;
    @(posedge clk);
    #1;
    check(peek_data, mem_m[a]);
  endtask

  task automatic exec(input logic [4:0] o, input logic [7:0] a, input logic [7:0] i);
    logic [7:0] r1;
    logic [7:0] r2;
    logic [15:0] ptr;
    int lat;
    int n;
    rnd(r1);
    rnd(r2);
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    addr <= a;
    imm <= i;
    rom_data_lo <= r1;
    rom_data_hi <= r2;
    @(posedge clk);
    start <= 1'b0;
    ptr = {mem_m[move_arith_pkg::ADDR_PTR_HIGH], mem_m[move_arith_pkg::ADDR_PTR_LOW]};
    n = model(o, a, i);
    #1;
    lat = 1;
    check(bad_target, n == 0);
    if (o == move_arith_pkg::OP_ROM_TABLE_READ)
    begin
      check({15'h0000, rom_rd}, 16'h0001);
      check(rom_addr, ptr);
    end
    while (done !== 1'b1 && lat < 4)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    if (n > 0)
      check(16'(lat), 16'(n));
    check(acc, acc_m);
    check({carry, digit_carry_flag, zero}, {c_m, dc_m, z_m});
    peek(a);
    peek(move_arith_pkg::ADDR_PROD_HIGH);
  endtask

  initial
  begin
    logic [7:0] ra;
    logic [7:0] rb;
    logic [7:0] rc;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({acc, carry, digit_carry_flag, zero, busy, done}, 16'h0000);
    // preload every byte so model and design start from the same memory
    for (int k = 0; k < 256; k++)
    begin
      rnd(ra);
      @(posedge clk);
      load_en <= 1'b1;
      load_addr <= 8'(k);
      load_data <= ra;
      mem_m[k] = ra;
    end
    @(posedge clk);
    load_en <= 1'b0;
    foreach (corner[k])
      exec(corner[k][20:16], corner[k][15:8], corner[k][7:0]);
    repeat (400)
    begin
      rnd(ra);
      rnd(rb);
      rnd(rc);
      exec(5'(ra % 8'd21), rb, rc);
    end
    final_report();
  end
endmodule
